//--- inc/uart_stby_regs.svh
`ifndef UART_STBY_REGS_SVH
`define UART_STBY_REGS_SVH
// --------------------------------------------------
// Register offsets (byte addresses)
// --------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_TRIG 8'h04
`define OFS_STAT 8'h08
`define OFS_FCLR 8'h0C
`define OFS_DATA 8'h10
`define OFS_PRS 8'h14
// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define CTRL_EIE 0
`define CTRL_SUP 1
`define CTRL_SWE 2
`define CTRL_NINE 3
`define CTRL_PEN 4
`define CTRL_ODD 5
`define TRIG_START 0
`define TRIG_STOP 1
`define FLAG_OVF 0
`define FLAG_FEF 1
`define FLAG_PEF 2
`define CTRL_RESET 6'h00
`define DIV_RESET 7'h00
// --------------------------------------------------
// Timing
// --------------------------------------------------
`define CLK_HZ 100000000
`define STBY_BAUD_BPS 4800
`define STBY_BIT_CYCLES (`CLK_HZ / `STBY_BAUD_BPS)
`endif

//--- inc/uart_stby_pkg.sv
package uart_stby_pkg;
  // Power mode of the receive channel
  typedef enum logic [2:0] {
    M_RUN = 3'b001,
    M_HALT = 3'b010,
    M_STANDBY = 3'b100
  } mode_e;
  // Frame receiver state
  typedef enum logic [3:0] {
    R_IDLE = 4'b0001,
    R_START = 4'b0010,
    R_SHIFT = 4'b0100,
    R_STOP = 4'b1000
  } rx_state_e;
endpackage : uart_stby_pkg

//--- rtl/uart_rx_standby_wakeup.sv
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - Error enable clear: never error interrupt
// - Enable set, no suppress: error interrupt
// - Suppress in standby: error flags untouched, no error interrupt; completion interrupt still raised with enable clear
// - Halted clock stops; edge enters standby
// - Start bit begins frame reception
// - Completion or error interrupt returns to run
// - Suppressed error with enable set returns to halt, no flags
// - Character readable in low data bits
// - Standby reception at fixed 4800 bps
`include "uart_stby_regs.svh"
module uart_rx_standby_wakeup
  import uart_stby_pkg::*;
#(
  parameter int BIT_CYCLES = `STBY_BIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic receive_line,
  input wire logic cpu_halted,
  output logic receive_complete_irq,
  output logic receive_error_irq,
  output logic clock_request
);
  // --------------------------------------------------
  // Declarations
  // --------------------------------------------------
  localparam int HALF = BIT_CYCLES / 2;
  logic [5:0] ctrl; // Control bits
  logic [6:0] divider; // Baud divider field, stored only
  logic [3:0] prescaler_select; // Stored only
  logic channel_enabled_status;
  logic [2:0] flags; // Parity, framing, overrun
  logic buf_full; // Unread character held
  logic [8:0] rx_data; // Last character
  logic wr_q; // Write data phase pending
  logic [7:0] addr_q;
  logic rx_s1, rx_s2, rx_s3, rx_lvl; // Line synchroniser
  logic rx_fall;
  mode_e mode;
  rx_state_e rstate;
  logic [15:0] baud; // Bit timer
  logic [3:0] idx; // Bit index in frame
  logic [9:0] shreg; // Data and parity bits
  logic acc, rd_data;
  logic [3:0] nbits;
  logic done_evt, fe, pe, ov, err, sup_now, drop_now;
  // Control aliases
  wire eie = ctrl[`CTRL_EIE];
  wire sup = ctrl[`CTRL_SUP];
  wire swe = ctrl[`CTRL_SWE];
  wire nine = ctrl[`CTRL_NINE];
  // --------------------------------------------------
  // Bus slave
  // --------------------------------------------------
  assign hreadyout = 1'b1; // Never stalls
  assign hresp = 1'b0; // Always OKAY
  assign acc = hsel && htrans[1] && hready && (hsize == 3'h2);
  assign rd_data = acc && !hwrite && (haddr[7:0] == `OFS_DATA);
  // Address phase capture and registered read data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      wr_q <= acc && hwrite;
      addr_q <= haddr[7:0];
      hrdata <= 32'h0;
      if (acc && !hwrite) begin
        unique case (haddr[7:0])
          `OFS_CTRL: hrdata <= {26'h0, ctrl};
          `OFS_STAT: hrdata <= {26'h0, flags, buf_full, rstate != R_IDLE, channel_enabled_status};
          `OFS_DATA: hrdata <= {16'h0, divider, nine ? rx_data : {1'b0, rx_data[7:0]}};
          `OFS_PRS: hrdata <= {28'h0, prescaler_select};
          default: hrdata <= 32'h0; // Unmapped reads zero
        endcase
      end
    end
  end
  // Register writes in the data phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl <= `CTRL_RESET;
      divider <= `DIV_RESET;
      prescaler_select <= 4'h0;
      channel_enabled_status <= 1'b0;
    end else if (wr_q) begin
      if (addr_q == `OFS_CTRL) ctrl <= hwdata[5:0];
      if (addr_q == `OFS_DATA) divider <= hwdata[15:9];
      if (addr_q == `OFS_PRS) prescaler_select <= hwdata[3:0];
      // Stop wins if both triggers are written together
      if (addr_q == `OFS_TRIG) begin
        if (hwdata[`TRIG_STOP]) channel_enabled_status <= 1'b0;
        else if (hwdata[`TRIG_START]) channel_enabled_status <= 1'b1;
      end
    end
  end
  // --------------------------------------------------
  // Line synchroniser
  // --------------------------------------------------
  // Level moves only when second and third stages agree
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_lvl <= 1'b1;
    end else begin
      rx_s1 <= receive_line;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3) rx_lvl <= rx_s2;
    end
  end
  assign rx_fall = rx_lvl && (rx_s2 == rx_s3) && !rx_s2;
  // --------------------------------------------------
  // Frame receiver
  // --------------------------------------------------
  assign nbits = (nine ? 4'd9 : 4'd8) + {3'h0, ctrl[`CTRL_PEN]};
  assign done_evt = (rstate == R_STOP) && (baud == 16'(BIT_CYCLES - 1));
  assign fe = !rx_lvl;
  assign pe = ctrl[`CTRL_PEN] && ((^(nine ? shreg[8:0] : {1'b0, shreg[7:0]})
              ^ shreg[nbits - 4'd1]) != ctrl[`CTRL_ODD]);
  assign ov = buf_full;
  assign err = fe || pe || ov;
  assign sup_now = sup && (mode == M_STANDBY);
  // Silent return to halt only with errors enabled; otherwise completion must still wake
  assign drop_now = err && sup_now && eie;
  // Bit timing; receiver only listens once halted when wakeup is armed
  always_ff @(posedge ref_clk) begin
    if (rst || !channel_enabled_status) begin
      rstate <= R_IDLE;
      baud <= 16'h0;
      idx <= 4'h0;
      shreg <= 10'h0;
    end else begin
      unique case (rstate)
        R_IDLE: begin
          if (rx_fall && (!swe || mode != M_RUN)) begin
            rstate <= R_START;
            baud <= 16'h0;
            shreg <= 10'h0;
          end
        end
        R_START: begin
          if (baud == 16'(HALF - 1)) begin
            baud <= 16'h0;
            idx <= 4'h0;
            rstate <= rx_lvl ? R_IDLE : R_SHIFT; // Glitch rejected
          end else baud <= baud + 16'h1;
        end
        R_SHIFT: begin
          if (baud == 16'(BIT_CYCLES - 1)) begin
            baud <= 16'h0;
            shreg[idx] <= rx_lvl;
            idx <= idx + 4'h1;
            if (idx == nbits - 4'd1) rstate <= R_STOP;
          end else baud <= baud + 16'h1;
        end
        R_STOP: begin
          if (done_evt) rstate <= R_IDLE;
          else baud <= baud + 16'h1;
        end
      endcase
    end
  end
  // --------------------------------------------------
  // Data buffer and error flags
  // --------------------------------------------------
  // Set wins over clear on every flag
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags <= 3'h0;
      buf_full <= 1'b0;
      rx_data <= 9'h0;
    end else begin
      if (rd_data) buf_full <= 1'b0;
      if (wr_q && addr_q == `OFS_FCLR) flags <= flags & ~hwdata[2:0];
      if (done_evt && !sup_now) begin
        if (ov) flags[`FLAG_OVF] <= 1'b1;
        if (fe) flags[`FLAG_FEF] <= 1'b1;
        if (pe) flags[`FLAG_PEF] <= 1'b1;
      end
      // Overrun keeps the unread character
      if (done_evt && !ov && !drop_now) begin
        rx_data <= nine ? shreg[8:0] : {1'b0, shreg[7:0]};
        buf_full <= 1'b1;
      end
    end
  end
  // --------------------------------------------------
  // Interrupt pulses
  // --------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      receive_complete_irq <= 1'b0;
      receive_error_irq <= 1'b0;
    end else begin
      receive_complete_irq <= done_evt && !(err && eie);
      receive_error_irq <= done_evt && err && eie && !sup_now;
    end
  end
  // --------------------------------------------------
  // Standby mode sequencer
  // --------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) mode <= M_RUN;
    else begin
      unique case (mode)
        M_RUN: if (swe && cpu_halted && channel_enabled_status) mode <= M_HALT;
        M_HALT: begin
          if (!swe || !cpu_halted || !channel_enabled_status) mode <= M_RUN;
          else if (rx_fall) mode <= M_STANDBY;
        end
        M_STANDBY: begin
          // back to halt; otherwise to run
          if (done_evt) mode <= drop_now ? M_HALT : M_RUN;
          else if (!swe || !channel_enabled_status) mode <= M_RUN;
        end
      endcase
    end
  end
  assign clock_request = (mode == M_STANDBY);
  // --------------------------------------------------
  // Checks
  // --------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_no_err_irq: assert property (!$past(eie) |-> !receive_error_irq)
    else $error("error interrupt with enable clear");
  chk_masked_done: assert property (done_evt && !eie |=> receive_complete_irq)
    else $error("completion missing with enable clear");
  chk_err_irq_raise: assert property (done_evt && err && eie && !sup_now |=> receive_error_irq)
    else $error("error interrupt missing");
  chk_flags_hold: assert property (done_evt && err && sup_now && !(wr_q && addr_q == `OFS_FCLR)
    |=> flags == $past(flags) && !receive_error_irq)
    else $error("flags changed under suppress");
  chk_wake_edge: assert property (mode == M_HALT && rx_fall && swe && cpu_halted && channel_enabled_status
    |=> mode == M_STANDBY ##1 rstate == R_START || rstate == R_SHIFT)
    else $error("edge did not wake");
  chk_start_recv: assert property (rstate == R_IDLE && rx_fall && swe && mode != M_RUN
    && channel_enabled_status |=> rstate == R_START)
    else $error("start bit missed");
  chk_exit_run: assert property (mode == M_STANDBY && done_evt && !drop_now
    |=> mode == M_RUN && (receive_complete_irq || receive_error_irq))
    else $error("no return to run");
  chk_back_halt: assert property (mode == M_STANDBY && done_evt && drop_now
    |=> mode == M_HALT && !receive_complete_irq)
    else $error("no return to halt");
  chk_data_low: assert property (done_evt && !ov && !err && !nine |=> buf_full && rx_data[8] == 1'b0)
    else $error("character not stored");
  chk_bit_time: assert property (rstate == R_SHIFT |-> baud < 16'(BIT_CYCLES))
    else $error("bit timer overran");
  chk_clk_req: assert property ($rose(mode == M_STANDBY) |-> clock_request [*2]
    or (clock_request ##1 mode != M_STANDBY))
    else $error("clock request dropped");
endmodule : uart_rx_standby_wakeup

//--- testbench/uart_far_tx.sv
`timescale 1ns/1ps
// ----------------------------------------
// Remote transmitter on the receive line
// ----------------------------------------
module uart_far_tx #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic ref_clk,
  output logic receive_line
);
  // Idle level is high, as the line pull-up leaves it
  initial receive_line = 1'b1;
  // One bit cell, changed just after an edge
  task automatic put(input logic v);
    receive_line <= v;
    repeat (BIT_CYCLES) @(posedge ref_clk);
  endtask : put
  // Exact fixed bit time, no rate offset
  // Start, LSB-first data, stop; a low stop forces a framing fault
  task automatic send(input logic [8:0] data, input int nbits, input logic stop_bit);
    put(1'b0);
    for (int i = 0; i < nbits; i++) begin
      put(data[i]);
    end
    put(stop_bit);
    receive_line <= 1'b1;
  endtask : send
endmodule : uart_far_tx

//--- testbench/uart_rx_standby_wakeup_test.sv
`timescale 1ns/1ps
`include "uart_stby_regs.svh"
module uart_rx_standby_wakeup_test;
  import uart_stby_pkg::*;
  // ----------------------------------------
  // Stimulus and observation
  // ----------------------------------------
  localparam int BC = 16; // Short bit time keeps the run brief
  localparam logic [3:0] STBY_PRS = 4'h5; // Standby operation clock select
  localparam logic [6:0] STBY_DIV = 7'h69; // Standby divider
  localparam logic [3:0] RUN_PRS = 4'h0; // Normal operation clock select
  localparam logic [6:0] RUN_DIV = 7'h67; // Normal divider
  logic ref_clk, rst, hsel, hwrite, hready, cpu_halted, receive_line;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, receive_complete_irq, receive_error_irq, clock_request;
  int num_errors = 0, cmp_count = 0, n_done = 0, n_err = 0, b_done, b_err;
  assign hready = hreadyout; // Single slave drives the bus ready
  uart_rx_standby_wakeup #(.BIT_CYCLES(BC)) i_dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .receive_line(receive_line), .cpu_halted(cpu_halted), .receive_complete_irq(receive_complete_irq),
    .receive_error_irq(receive_error_irq), .clock_request(clock_request));
  uart_far_tx #(.BIT_CYCLES(BC)) i_far (.ref_clk(ref_clk), .receive_line(receive_line));
  // Interrupt pulses last one cycle, so they are counted here
  always @(posedge ref_clk) begin
    n_done <= n_done + int'(receive_complete_irq === 1'b1);
    n_err <= n_err + int'(receive_error_irq === 1'b1);
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("mismatches %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // One single-word transfer; waits are bounded
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= wr; haddr <= {24'h0, a}; hsize <= 3'h2;
    i = 0;
    do begin @(posedge ref_clk); i++; end while (hready !== 1'b1 && i < 20);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    do begin @(posedge ref_clk); i++; end while (hready !== 1'b1 && i < 40);
    q = hrdata;
    if (hready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask : bus
  // Return to run mode, stop channel, clear flags, drain data, restart
  task automatic cleanup;
    cpu_halted <= 1'b0;
    bus(1, `OFS_TRIG, 32'h2);
    bus(1, `OFS_CTRL, 32'h0);
    bus(1, `OFS_FCLR, 32'h7);
    bus(0, `OFS_DATA, 32'h0);
    bus(1, `OFS_PRS, {28'h0, RUN_PRS});
    bus(1, `OFS_DATA, {16'h0, RUN_DIV, 9'h0});
    bus(1, `OFS_TRIG, 32'h1);
    bus(1, 8'h18, 32'hFFFFFFFF); // Unmapped write is ignored
  endtask : cleanup
  // Arm standby, halt, send one frame, count interrupts
  task automatic standby(input logic [31:0] ctrl, input logic [8:0] d, input int nb, input logic sb,
                         input int e_done, input int e_err);
    bus(0, `OFS_STAT, 32'h0);
    check(q[1], 1'b0);
    bus(1, `OFS_TRIG, 32'h2);
    bus(1, `OFS_FCLR, 32'h7);
    bus(0, `OFS_DATA, 32'h0);
    bus(1, `OFS_PRS, {28'h0, STBY_PRS});
    bus(1, `OFS_DATA, {16'h0, STBY_DIV, 9'h0});
    bus(0, `OFS_DATA, 32'h0);
    check(q[15:9], STBY_DIV);
    bus(1, `OFS_CTRL, ctrl | 32'h4);
    bus(1, `OFS_TRIG, 32'h1);
    cpu_halted <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(clock_request, 1'b0);
    b_done = n_done;
    b_err = n_err;
    fork
      i_far.send(d, nb, sb);
      begin
        repeat (2 * BC) @(posedge ref_clk);
        check(clock_request, 1'b1);
      end
    join
    repeat (8) @(posedge ref_clk);
    check(n_done - b_done, e_done);
    check(n_err - b_err, e_err);
  endtask : standby
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_err_masked;
    standby(32'h0, 9'h055, 8, 1'b0, 1, 0);
    check(clock_request, 1'b0);
    cleanup();
    standby(32'h2, 9'h055, 8, 1'b0, 1, 0);
    check(clock_request, 1'b0);
    bus(0, `OFS_STAT, 32'h0);
    check(q[5:3], 3'h0);
    cleanup();
  endtask : s_err_masked
  task automatic s_parity;
    standby(32'h11, 9'h155, 9, 1'b1, 0, 1);
    bus(0, `OFS_STAT, 32'h0);
    check(q[5], 1'b1);
    cleanup();
    standby(32'h31, 9'h155, 9, 1'b1, 1, 0);
    bus(0, `OFS_DATA, 32'h0);
    check(q[8:0], 9'h055);
    cleanup();
  endtask : s_parity
  task automatic s_err_raised;
    standby(32'h1, 9'h055, 8, 1'b0, 0, 1);
    check(clock_request, 1'b0);
    bus(0, `OFS_STAT, 32'h0);
    check(q[4], 1'b1);
    cleanup();
  endtask : s_err_raised
  task automatic s_suppress;
    standby(32'h3, 9'h055, 8, 1'b0, 0, 0);
    check(clock_request, 1'b0);
    fork
      i_far.send(9'h0A5, 8, 1'b1);
      begin
        repeat (2 * BC) @(posedge ref_clk);
        check(clock_request, 1'b1);
      end
    join
    repeat (8) @(posedge ref_clk);
    check(n_done - b_done, 1);
    bus(0, `OFS_STAT, 32'h0);
    check(q[5:3], 3'h0);
    bus(0, `OFS_DATA, 32'h0);
    check(q[8:0], 9'h0A5);
    check(hresp, 1'b0);
    cleanup();
  endtask : s_suppress
  task automatic s_nine_bit;
    standby(32'h9, 9'h1C3, 9, 1'b1, 1, 0);
    bus(0, `OFS_DATA, 32'h0);
    check(q[8:0], 9'h1C3);
    cleanup();
  endtask : s_nine_bit
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; cpu_halted = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    s_err_masked();
    s_err_raised();
    s_suppress();
    s_nine_bit();
    s_parity();
    end_sim();
  end
endmodule : uart_rx_standby_wakeup_test
